// [rtl/mistat_top.sv]
// Motion and image statistics test registers read by the host.
`timescale 1ns/1ps
module mistat_top
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic usb_reset,
    input wire logic rd_valid,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output logic rd_done,
    input wire logic report_valid,
    input wire logic [mistat_pkg::MISTAT_DELTA_W-1:0] report_dx,
    input wire logic [mistat_pkg::MISTAT_DELTA_W-1:0] report_dy,
    input wire logic frame_valid,
    input wire logic [7:0] frame_quality,
    input wire logic [15:0] frame_shutter,
    input wire logic [mistat_pkg::MISTAT_PEAK_W-1:0] frame_peak,
    input wire logic [mistat_pkg::MISTAT_SUM_W-1:0] frame_sum,
    input wire logic wheel_a,
    input wire logic wheel_b
);
    import mistat_pkg::*;

    // ------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------
    logic [MISTAT_DELTA_W-1:0] dx_q, dx_d; // Last queued X delta.
    logic [MISTAT_DELTA_W-1:0] dy_q, dy_d; // Last queued Y delta.
    logic x_seen_q, x_seen_d; // X low was read since the last report.
    logic [7:0] quality_q, quality_d;
    logic [15:0] shut_q, shut_d;
    logic [7:0] shadow_q, shadow_d; // Low byte caught at a high read.
    logic shadow_ok_q, shadow_ok_d; // Shadow holds an unread low byte.
    logic [MISTAT_PEAK_W-1:0] peak_q, peak_d;
    logic [7:0] sum_q, sum_d;
    logic [7:0] rd_data_d;

    mistat_wheel_if wif ();

    // The wheel count is cleared by a bus reset, like the others.
    assign wif.clear = usb_reset;

    mistat_wheel u_wheel
    (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .wheel_a(wheel_a),
        .wheel_b(wheel_b),
        .wif(wif)
    );

    // ------------------------------------------------------------
    // Next values of the register file.
    // ------------------------------------------------------------
    // Deltas are stored raw; the report path already applied the
    // resolution scale, so the host sees the same counts.
    always_comb
    begin
        dx_d = dx_q;
        dy_d = dy_q;
        x_seen_d = x_seen_q;
        quality_d = quality_q;
        shut_d = shut_q;
        shadow_d = shadow_q;
        shadow_ok_d = shadow_ok_q;
        peak_d = peak_q;
        sum_d = sum_q;
        if (report_valid)
        begin
            dx_d = report_dx;
            dy_d = report_dy;
            x_seen_d = 1'b0; // New report: the order starts over.
        end
        if (frame_valid)
        begin
            // Clamp guards against a noisy count above the ceiling.
            quality_d = (frame_quality > MISTAT_QUALITY_MAX) ?
                MISTAT_QUALITY_MAX : frame_quality;
            shut_d = frame_shutter;
            peak_d = frame_peak;
            sum_d = frame_sum[MISTAT_SUM_LSB +: 8];
        end
        if (rd_valid && rd_addr == MISTAT_ADDR_X_LOW)
        begin
            // The read wins over a report in the same cycle.
            x_seen_d = 1'b1;
        end
        if (rd_valid && rd_addr == MISTAT_ADDR_SHUT_HIGH)
        begin
            // Keeps a later frame from tearing the 16-bit pair.
            shadow_d = shut_q[7:0];
            shadow_ok_d = 1'b1;
        end
        else if (rd_valid && rd_addr == MISTAT_ADDR_SHUT_LOW)
        begin
            shadow_ok_d = 1'b0;
        end
        if (usb_reset)
        begin
            // The registers fall back as after power loss.
            dx_d = '0;
            dy_d = '0;
            x_seen_d = 1'b0;
            quality_d = MISTAT_RST_BYTE;
            shut_d = MISTAT_RST_SHUT;
            shadow_d = MISTAT_RST_BYTE;
            shadow_ok_d = 1'b0;
            peak_d = '0;
            sum_d = MISTAT_RST_BYTE;
        end
    end

    // Register file flip-flops.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dx_q <= '0;
            dy_q <= '0;
            x_seen_q <= 1'b0;
            quality_q <= MISTAT_RST_BYTE;
            shut_q <= MISTAT_RST_SHUT;
            shadow_q <= MISTAT_RST_BYTE;
            shadow_ok_q <= 1'b0;
            peak_q <= '0;
            sum_q <= MISTAT_RST_BYTE;
        end
        else
        begin
            dx_q <= dx_d;
            dy_q <= dy_d;
            x_seen_q <= x_seen_d;
            quality_q <= quality_d;
            shut_q <= shut_d;
            shadow_q <= shadow_d;
            shadow_ok_q <= shadow_ok_d;
            peak_q <= peak_d;
            sum_q <= sum_d;
        end
    end

    // ------------------------------------------------------------
    // Read port.
    // ------------------------------------------------------------
    // These are a test view only; navigation goes through the
    // regular reports, so no read here disturbs the motion path.
    always_comb
    begin
        rd_data_d = MISTAT_RST_BYTE;
        case (rd_addr)
            MISTAT_ADDR_X_LOW: rd_data_d = dx_q[7:0];
            MISTAT_ADDR_Y_LOW:
            begin
                // Out of order the host gets zero.
                rd_data_d = x_seen_q ? dy_q[7:0] : MISTAT_RST_BYTE;
            end
            MISTAT_ADDR_XY_HIGH:
            begin
                rd_data_d = x_seen_q ?
                    {dx_q[MISTAT_NIBBLE_LSB +: 4],
                     dy_q[MISTAT_NIBBLE_LSB +: 4]} : MISTAT_RST_BYTE;
            end
            MISTAT_ADDR_WHEEL: rd_data_d = wif.count;
            MISTAT_ADDR_QUALITY: rd_data_d = quality_q;
            MISTAT_ADDR_SHUT_HIGH: rd_data_d = shut_q[15:8];
            MISTAT_ADDR_SHUT_LOW:
            begin
                // Host reading high first gets the caught byte.
                rd_data_d = shadow_ok_q ? shadow_q : shut_q[7:0];
            end
            MISTAT_ADDR_PEAK: rd_data_d = {1'b0, peak_q};
            MISTAT_ADDR_SUM_HIGH: rd_data_d = sum_q;
            default: rd_data_d = MISTAT_RST_BYTE;
        endcase
    end

    // Answer registers: data and done one cycle after the request.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_data <= MISTAT_RST_BYTE;
            rd_done <= 1'b0;
        end
        else
        begin
            rd_done <= rd_valid;
            if (rd_valid)
            begin
                rd_data <= rd_data_d;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    property p_order_zero;
        @(posedge sys_clk) disable iff (!nrst)
        (rd_valid && !x_seen_q && (rd_addr == MISTAT_ADDR_Y_LOW ||
         rd_addr == MISTAT_ADDR_XY_HIGH)) |=> rd_done && rd_data == 8'h00;
    endproperty
    a_order_zero: assert property (p_order_zero)
        else $error("out of order delta read not zero");

    property p_x_marks;
        @(posedge sys_clk) disable iff (!nrst)
        (rd_valid && rd_addr == MISTAT_ADDR_X_LOW && !usb_reset)
        |=> x_seen_q;
    endproperty
    a_x_marks: assert property (p_x_marks)
        else $error("x low read did not open y reads");

    property p_y_low;
        @(posedge sys_clk) disable iff (!nrst)
        (rd_valid && x_seen_q && rd_addr == MISTAT_ADDR_Y_LOW)
        |=> rd_data == $past(dy_q[7:0]);
    endproperty
    a_y_low: assert property (p_y_low)
        else $error("y low mismatch");

    property p_high;
        @(posedge sys_clk) disable iff (!nrst)
        (rd_valid && x_seen_q && rd_addr == MISTAT_ADDR_XY_HIGH)
        |=> rd_data == {$past(dx_q[11:8]), $past(dy_q[11:8])};
    endproperty
    a_high: assert property (p_high)
        else $error("high nibble packing wrong");

    property p_x_low;
        @(posedge sys_clk) disable iff (!nrst)
        report_valid && !usb_reset ##1
        (rd_valid && rd_addr == MISTAT_ADDR_X_LOW && !report_valid)
        |=> rd_data == $past(report_dx[7:0], 2);
    endproperty
    a_x_low: assert property (p_x_low)
        else $error("x low not from last report");

    property p_quality;
        @(posedge sys_clk) disable iff (!nrst)
        quality_q <= MISTAT_QUALITY_MAX;
    endproperty
    a_quality: assert property (p_quality)
        else $error("quality above ceiling");

    property p_peak;
        @(posedge sys_clk) disable iff (!nrst)
        (rd_valid && rd_addr == MISTAT_ADDR_PEAK) |=> !rd_data[7];
    endproperty
    a_peak: assert property (p_peak)
        else $error("peak bit 7 set");

    property p_sum;
        @(posedge sys_clk) disable iff (!nrst)
        (frame_valid && !usb_reset) |=> sum_q == $past(frame_sum[15:8]);
    endproperty
    a_sum: assert property (p_sum)
        else $error("sum byte not bits 15..8");

    property p_shadow;
        @(posedge sys_clk) disable iff (!nrst)
        (rd_valid && rd_addr == MISTAT_ADDR_SHUT_HIGH && !usb_reset) ##1
        (rd_valid && rd_addr == MISTAT_ADDR_SHUT_LOW)
        |=> rd_data == $past(shut_q[7:0], 2);
    endproperty
    a_shadow: assert property (p_shadow)
        else $error("shutter low torn");

    property p_bus_reset;
        @(posedge sys_clk) disable iff (!nrst)
        usb_reset |=> shut_q == MISTAT_RST_SHUT && dx_q == '0 && !x_seen_q;
    endproperty
    a_bus_reset: assert property (p_bus_reset)
        else $error("bus reset did not restore values");

    c_ordered: cover property (@(posedge sys_clk) disable iff (!nrst)
        rd_valid && rd_addr == MISTAT_ADDR_X_LOW ##1
        rd_valid && rd_addr == MISTAT_ADDR_Y_LOW);
    c_shutter_pair: cover property (@(posedge sys_clk) disable iff (!nrst)
        rd_valid && rd_addr == MISTAT_ADDR_SHUT_HIGH ##[1:4]
        rd_valid && rd_addr == MISTAT_ADDR_SHUT_LOW && frame_valid);
    c_wheel_max: cover property (@(posedge sys_clk) disable iff (!nrst)
        wif.count == MISTAT_WHEEL_MAX);
endmodule

// [rtl/mistat_pkg.sv]
// Package of offsets, field positions and reset values for the stats block.
package mistat_pkg;

    // ------------------------------------------------------------
    // Register offsets on the host read port.
    // ------------------------------------------------------------
    localparam logic [7:0] MISTAT_ADDR_X_LOW = 8'h03;
    localparam logic [7:0] MISTAT_ADDR_Y_LOW = 8'h04;
    localparam logic [7:0] MISTAT_ADDR_XY_HIGH = 8'h05;
    localparam logic [7:0] MISTAT_ADDR_WHEEL = 8'h06;
    localparam logic [7:0] MISTAT_ADDR_QUALITY = 8'h07;
    localparam logic [7:0] MISTAT_ADDR_SHUT_HIGH = 8'h08;
    localparam logic [7:0] MISTAT_ADDR_SHUT_LOW = 8'h09;
    localparam logic [7:0] MISTAT_ADDR_PEAK = 8'h0a;
    localparam logic [7:0] MISTAT_ADDR_SUM_HIGH = 8'h0b;

    // ------------------------------------------------------------
    // Widths, field positions and limits.
    // ------------------------------------------------------------
    localparam int MISTAT_DELTA_W = 12;
    localparam int MISTAT_NIBBLE_LSB = 8;
    localparam int MISTAT_SUM_W = 17;
    localparam int MISTAT_SUM_LSB = 8;
    localparam int MISTAT_PEAK_W = 7;
    localparam logic [7:0] MISTAT_QUALITY_MAX = 8'h80;
    localparam logic signed [7:0] MISTAT_WHEEL_MAX = 8'sh7f;
    localparam logic signed [7:0] MISTAT_WHEEL_MIN = -8'sh7f;

    // ------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------
    localparam logic [7:0] MISTAT_RST_BYTE = 8'h00;
    localparam logic [15:0] MISTAT_RST_SHUT = 16'h0064;

    // Direction step of the wheel decoder.
    typedef enum {MISTAT_STEP_NONE, MISTAT_STEP_UP, MISTAT_STEP_DOWN}
        mistat_step_e;

endpackage

// [rtl/mistat_wheel_if.sv]
// Interface carrying the wheel count from the decoder to the register file.
`timescale 1ns/1ps
interface mistat_wheel_if;
    logic signed [7:0] count; // Saturated signed wheel count.
    logic clear; // Synchronous clear from a bus reset.

    modport counter (output count, input clear);
    modport user (input count, output clear);
endinterface

// [rtl/mistat_wheel.sv]
// Quadrature wheel decoder with a saturating signed count.
`timescale 1ns/1ps
module mistat_wheel
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic wheel_a,
    input wire logic wheel_b,
    mistat_wheel_if.counter wif
);
    import mistat_pkg::*;

    // ------------------------------------------------------------
    // State.
    // ------------------------------------------------------------
    logic [1:0] sync1_q; // First synchroniser stage, read only by stage two.
    logic [1:0] sync2_q; // Second stage, safe to decode.
    logic [1:0] prev_q; // Last decoded phase pair.
    logic signed [7:0] count_q;
    logic signed [7:0] count_d;
    mistat_step_e step;

    // Decode one phase change; a double jump is ignored as noise.
    function automatic mistat_step_e decode(input logic [1:0] p,
                                            input logic [1:0] c);
        decode = MISTAT_STEP_NONE;
        case ({p, c})
            4'b0001, 4'b0111, 4'b1110, 4'b1000: decode = MISTAT_STEP_UP;
            4'b0010, 4'b1011, 4'b1101, 4'b0100: decode = MISTAT_STEP_DOWN;
            default: decode = MISTAT_STEP_NONE;
        endcase
    endfunction

    // Next count: step and clamp so the value stays symmetric.
    always_comb
    begin
        step = decode(prev_q, sync2_q);
        count_d = count_q;
        if (wif.clear)
        begin
            count_d = '0;
        end
        else if (step == MISTAT_STEP_UP && count_q != MISTAT_WHEEL_MAX)
        begin
            count_d = count_q + 8'sd1;
        end
        else if (step == MISTAT_STEP_DOWN && count_q != MISTAT_WHEEL_MIN)
        begin
            count_d = count_q - 8'sd1;
        end
    end

    // Registers; pins pass two flip-flops before decoding.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
            count_q <= '0;
        end
        else
        begin
            sync1_q <= {wheel_a, wheel_b};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            count_q <= count_d;
        end
    end

    assign wif.count = count_q;

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    property p_wheel_range;
        @(posedge sys_clk) disable iff (!nrst)
        count_q >= MISTAT_WHEEL_MIN && count_q <= MISTAT_WHEEL_MAX;
    endproperty
    a_wheel_range: assert property (p_wheel_range)
        else $error("wheel count out of range");

    property p_wheel_up;
        @(posedge sys_clk) disable iff (!nrst)
        (step == MISTAT_STEP_UP && !wif.clear && count_q < MISTAT_WHEEL_MAX)
        |=> count_q == $past(count_q) + 8'sd1;
    endproperty
    a_wheel_up: assert property (p_wheel_up)
        else $error("wheel did not count up");
endmodule

// [testbench/mistat_host_model.sv]
// Host model that reads the test registers over the block's read port.
`timescale 1ns/1ps
module mistat_host_model
(
    input wire logic sys_clk,
    input wire logic rd_done,
    input wire logic [7:0] rd_data,
    output logic rd_valid,
    output logic [7:0] rd_addr
);
    // Idle port at time zero: no request outstanding.
    initial
    begin
        rd_valid = 1'b0;
        rd_addr = 8'hff;
    end

    // ------------------------------------------------------------
    // Single read transfer.
    // ------------------------------------------------------------
    // The request is a one-cycle pulse; the answer strobe is looked
    // at in the cycle after the taking edge, where it stands.
    task automatic read(input logic [7:0] a, output logic [7:0] d,
                        output logic ok);
        @(posedge sys_clk);
        rd_valid <= 1'b1;
        rd_addr <= a;
        @(posedge sys_clk);
        // A released address shows its inverse, never a stale copy.
        rd_valid <= 1'b0;
        rd_addr <= ~a;
        #1;
        ok = rd_done;
        d = rd_data;
    endtask

    // ------------------------------------------------------------
    // Back-to-back pair of reads.
    // ------------------------------------------------------------
    // The second request rides straight on the first, as the port
    // allows, so ordered pairs are taken on two adjacent edges.
    task automatic read_pair(input logic [7:0] a0, input logic [7:0] a1,
                             output logic [7:0] d0, output logic [7:0] d1,
                             output logic ok);
        logic ok0;
        @(posedge sys_clk);
        rd_valid <= 1'b1;
        rd_addr <= a0;
        @(posedge sys_clk);
        rd_addr <= a1;
        #1;
        ok0 = rd_done;
        d0 = rd_data;
        @(posedge sys_clk);
        rd_valid <= 1'b0;
        rd_addr <= ~a1;
        #1;
        ok = rd_done & ok0;
        d1 = rd_data;
    endtask

    // Shutter pair read, high byte first so both halves match.
    task automatic read_shutter(output logic [15:0] s, output logic ok);
        read_pair(8'h08, 8'h09, s[15:8], s[7:0], ok);
    endtask
endmodule

// [testbench/mistat_tb_top.sv]
// Self-checking testbench for the motion and image statistics registers.
`timescale 1ns/1ps
module mistat_tb_top;
    import mistat_pkg::*;

    // ------------------------------------------------------------
    // Stimulus signals and bookkeeping.
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic usb_reset = 1'b0;
    logic rd_valid;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_done;
    logic report_valid = 1'b0;
    logic [11:0] report_dx = 12'h000;
    logic [11:0] report_dy = 12'h000;
    logic frame_valid = 1'b0;
    logic [7:0] frame_quality = 8'h00;
    logic [15:0] frame_shutter = 16'h0000;
    logic [6:0] frame_peak = 7'h00;
    logic [16:0] frame_sum = 17'h00000;
    logic wheel_a = 1'b0;
    logic wheel_b = 1'b0;
    logic [1:0] ph = 2'd0; // Quadrature phase index of the wheel.
    int fails = 0;
    int check_count = 0;
    int cycles = 0;

    // Free-running 100 MHz clock.
    always #5 sys_clk = ~sys_clk;

    mistat_top dut_u
    (
        .sys_clk(sys_clk), .nrst(nrst), .usb_reset(usb_reset),
        .rd_valid(rd_valid), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_done(rd_done), .report_valid(report_valid),
        .report_dx(report_dx), .report_dy(report_dy),
        .frame_valid(frame_valid), .frame_quality(frame_quality),
        .frame_shutter(frame_shutter), .frame_peak(frame_peak),
        .frame_sum(frame_sum), .wheel_a(wheel_a), .wheel_b(wheel_b)
    );

    mistat_host_model host_u
    (
        .sys_clk(sys_clk), .rd_done(rd_done), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_addr(rd_addr)
    );

    // ------------------------------------------------------------
    // Compare, verdict and timeout.
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // The whole run needs about 2500 cycles; the ceiling leaves room.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Drivers.
    // ------------------------------------------------------------
    // Read one register and judge both the strobe and the byte.
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        host_u.read(a, d, ok);
        chk("read strobe", 8'h01, {7'h00, ok});
        chk($sformatf("reg %h", a), e, d);
    endtask

    // Read two registers on adjacent edges and judge both bytes.
    task automatic rdp(input logic [7:0] a0, input logic [7:0] a1,
                       input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] d0;
        logic [7:0] d1;
        logic ok;
        host_u.read_pair(a0, a1, d0, d1, ok);
        chk("pair strobe", 8'h01, {7'h00, ok});
        chk($sformatf("reg %h", a0), e0, d0);
        chk($sformatf("reg %h", a1), e1, d1);
    endtask

    task automatic report(input logic [11:0] dx, input logic [11:0] dy);
        @(posedge sys_clk);
        report_valid <= 1'b1;
        report_dx <= dx;
        report_dy <= dy;
        @(posedge sys_clk);
        report_valid <= 1'b0;
    endtask

    task automatic frame(input logic [7:0] q, input logic [15:0] s,
                         input logic [6:0] p, input logic [16:0] sum);
        @(posedge sys_clk);
        frame_valid <= 1'b1;
        {frame_quality, frame_shutter, frame_peak, frame_sum} <=
            {q, s, p, sum};
        @(posedge sys_clk);
        frame_valid <= 1'b0;
    endtask

    task automatic bus_reset();
        @(posedge sys_clk);
        usb_reset <= 1'b1;
        @(posedge sys_clk);
        usb_reset <= 1'b0;
    endtask

    // Gray steps 00, 01, 11, 10 count up; slow enough for the synchroniser.
    task automatic turn(input int n, input bit up);
        for (int i = 0; i < n; i++)
        begin
            ph = up ? ph + 2'd1 : ph - 2'd1;
            @(posedge sys_clk);
            {wheel_a, wheel_b} <= {ph[1], ph[1] ^ ph[0]};
            repeat (5) @(posedge sys_clk);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    // Every register and two unmapped places read their reset value.
    task automatic t_reset();
        for (int a = 3; a < 12; a++)
            rdc(8'(a), (a == 9) ? 8'h64 : 8'h00);
        rdc(8'h0c, 8'h00);
        rdc(8'hff, 8'h00);
    endtask

    // Y low and high read zero until X low is read after a report.
    task automatic t_motion();
        report(12'ha5c, 12'h3e1);
        rdc(8'h04, 8'h00);
        rdc(8'h05, 8'h00);
        rdc(8'h03, 8'h5c);
        rdc(8'h04, 8'he1);
        rdc(8'h05, 8'ha3);
        report(12'h801, 12'h7ff);
        rdc(8'h04, 8'h00);
        rdc(8'h03, 8'h01);
        rdc(8'h05, 8'h87);
        // X low taken on the edge right after a report, then Y low.
        fork
            report(12'h0c3, 12'hf2e);
            begin
                @(posedge sys_clk);
                rdp(8'h03, 8'h04, 8'hc3, 8'h2e);
            end
        join
    endtask

    // Image statistics, clamps and the shutter snapshot.
    task automatic t_frame();
        logic [15:0] s;
        logic ok;
        frame(8'hc8, 16'h1234, 7'h7f, 17'h1abcd);
        rdc(8'h07, 8'h80);
        rdc(8'h0a, 8'h7f);
        rdc(8'h0b, 8'hab);
        rdc(8'h08, 8'h12);
        frame(8'h80, 16'h5678, 7'h01, 17'h0ff00);
        rdc(8'h09, 8'h34);
        rdc(8'h09, 8'h78);
        rdc(8'h07, 8'h80);
        rdc(8'h0b, 8'hff);
        // High then low on adjacent edges: the caught low byte answers.
        host_u.read_shutter(s, ok);
        chk("shutter strobe", 8'h01, {7'h00, ok});
        chk("shutter high", 8'h56, s[15:8]);
        chk("shutter low", 8'h78, s[7:0]);
    endtask

    // A bus reset clears statistics, the order flag and the wheel.
    task automatic t_bus_reset();
        turn(3, 1'b1);
        rdc(8'h06, 8'h03);
        rdc(8'h03, 8'hc3);
        bus_reset();
        rdc(8'h04, 8'h00);
        rdc(8'h03, 8'h00);
        rdc(8'h09, 8'h64);
        rdc(8'h0a, 8'h00);
        rdc(8'h06, 8'h00);
    endtask

    // Wheel counts each step and saturates at both ends.
    task automatic t_wheel();
        turn(5, 1'b1);
        rdc(8'h06, 8'h05);
        turn(130, 1'b1);
        rdc(8'h06, 8'h7f);
        turn(2, 1'b0);
        rdc(8'h06, 8'h7d);
        turn(260, 1'b0);
        rdc(8'h06, 8'h81);
    endtask

    // Main sequence: reset held for 16 cycles, then the scenarios.
    initial
    begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_motion();
        t_frame();
        t_bus_reset();
        t_wheel();
        print_verdict();
    end
endmodule
